// [design/bbx_alu.sv]
// constants package and the 8-bit add/and datapath of the byte and branch executor
`timescale 1ns/1ps
`default_nettype none

package bbx_pkg;
  // register byte offsets on the ahb-lite window
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_WREG = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_BANK = 8'h0c;
  localparam logic [7:0] OFS_PC = 8'h10;
  localparam logic [7:0] OFS_CFG = 8'h14;
  localparam logic [7:0] OFS_IDXB = 8'h18;
  localparam logic [7:0] OFS_INFO = 8'h1c;
  // widths
  localparam int PC_W = 21;
  localparam int DA_W = 12;
  localparam int BANK_W = 4;
  // status flag positions
  localparam int FLG_C = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N = 4;
  localparam int FLG_W = 5;
  // instruction word fields
  localparam int DEST_BIT = 9;
  localparam int ACC_BIT = 8;
  localparam logic [15:0] ADDC_MASK = 16'hfc00;
  localparam logic [15:0] ADDC_MATCH = 16'h2000;
  localparam logic [15:0] ANDF_MASK = 16'hfc00;
  localparam logic [15:0] ANDF_MATCH = 16'h1400;
  localparam logic [15:0] ANDL_MASK = 16'hff00;
  localparam logic [15:0] ANDL_MATCH = 16'h0b00;
  localparam logic [15:0] BRC_MASK = 16'hff00;
  localparam logic [15:0] BRC_MATCH = 16'he200;
  // addressing
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  localparam logic [7:0] ACC_SPLIT = 8'h80;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  // pc step, reset values and info cycle counts
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] PC_RST = 21'h000000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  // info and cfg register fields
  localparam int INFO_BUSY = 0;
  localparam int INFO_CYC_LO = 1;
  localparam int INFO_BAD = 3;
  localparam int CFG_EXT = 0;
  // execution states, one-hot
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_Q1 = 9'h002,
    ST_Q2 = 9'h004,
    ST_Q3 = 9'h008,
    ST_Q4 = 9'h010,
    ST_N1 = 9'h020,
    ST_N2 = 9'h040,
    ST_N3 = 9'h080,
    ST_N4 = 9'h100
  } bbx_state_t;
endpackage

module bbx_alu (
  // operands
  input wire logic [7:0] acc_i,
  input wire logic [7:0] opnd_i,
  input wire logic carry_i,
  input wire logic sel_add_i,
  // results
  output logic [7:0] res_o,
  output logic c_o,
  output logic dc_o,
  output logic ov_o,
  output logic n_o,
  output logic z_o
);
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [7:0] and8;

  assign sum9 = {1'b0, acc_i} + {1'b0, opnd_i} + {8'h00, carry_i};
  assign nib5 = {1'b0, acc_i[3:0]} + {1'b0, opnd_i[3:0]} + {4'h0, carry_i};
  assign and8 = acc_i & opnd_i;
  assign res_o = sel_add_i ? sum9[7:0] : and8;
  assign c_o = sum9[8];
  assign dc_o = nib5[4];
  assign ov_o = (acc_i[7] == opnd_i[7]) && (sum9[7] != acc_i[7]);
  assign n_o = res_o[7];
  assign z_o = (res_o == 8'h00);
endmodule

`default_nettype wire

// [design/bbx_exec.sv]
// byte and branch instruction executor with ahb-lite register window
`timescale 1ns/1ps
`default_nettype none

module bbx_exec (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // data memory port, combinational read
  output logic [11:0] dmem_addr_o,
  output logic [7:0] dmem_wdata_o,
  output logic dmem_we_o,
  input wire logic [7:0] dmem_rdata_i,
  // status
  output logic busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic op_match(input logic [15:0] word, input logic [15:0] mask,
                                    input logic [15:0] match);
    op_match = ((word & mask) == match);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  bbx_pkg::bbx_state_t state_r;
  bbx_pkg::bbx_state_t state_nxt;
  logic [15:0] ir_r;
  logic [7:0] w_r;
  logic [bbx_pkg::FLG_W-1:0] stat_r;
  logic [bbx_pkg::BANK_W-1:0] bank_r;
  logic [bbx_pkg::PC_W-1:0] pc_r;
  logic ext_r;
  logic [bbx_pkg::DA_W-1:0] idxb_r;
  logic [7:0] opnd_r;
  logic [7:0] res_r;
  logic [bbx_pkg::FLG_W-1:0] flg_r;
  logic taken_r;
  logic bad_r;
  logic [1:0] cyc_r;
  logic [11:0] dmem_addr_r;
  logic [7:0] dmem_wdata_r;
  logic dmem_we_r;
  logic busy_r;
  // ahb pipeline
  logic a_valid_r;
  logic a_write_r;
  logic [7:0] a_addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  logic is_addc;
  logic is_andf;
  logic is_andl;
  logic is_brc;
  logic is_file;
  logic dest_file;
  logic acc_bit;
  logic [7:0] fadr;
  logic use_idx;
  logic [11:0] ea;
  logic [bbx_pkg::PC_W-1:0] br_off;
  logic [bbx_pkg::PC_W-1:0] br_target;

  assign is_addc = op_match(ir_r, bbx_pkg::ADDC_MASK, bbx_pkg::ADDC_MATCH);
  assign is_andf = op_match(ir_r, bbx_pkg::ANDF_MASK, bbx_pkg::ANDF_MATCH);
  assign is_andl = op_match(ir_r, bbx_pkg::ANDL_MASK, bbx_pkg::ANDL_MATCH);
  assign is_brc = op_match(ir_r, bbx_pkg::BRC_MASK, bbx_pkg::BRC_MATCH);
  assign is_file = is_addc || is_andf;
  assign dest_file = ir_r[bbx_pkg::DEST_BIT];
  assign acc_bit = ir_r[bbx_pkg::ACC_BIT];
  assign fadr = ir_r[7:0];
  // indexed mode wins over the access bank only for the low part of it
  assign use_idx = !acc_bit && ext_r && (fadr <= bbx_pkg::IDX_LIMIT);
  assign ea = use_idx ? (idxb_r + {4'h0, fadr})
            : acc_bit ? {bank_r, fadr}
            : (fadr < bbx_pkg::ACC_SPLIT) ? {bbx_pkg::ACC_LO_BANK, fadr}
            : {bbx_pkg::ACC_HI_BANK, fadr};
  // pc_r already holds the incremented pc when this is used
  assign br_off = {{(bbx_pkg::PC_W-9){ir_r[7]}}, ir_r[7:0], 1'b0};
  assign br_target = pc_r + br_off;

  ////////////////////////////////////////////////////////////////////////////
  // alu

  logic [7:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_ov;
  logic alu_n;
  logic alu_z;
  logic [bbx_pkg::FLG_W-1:0] flg_add;
  logic [bbx_pkg::FLG_W-1:0] flg_and;

  bbx_alu u_alu (
    .acc_i(w_r),
    .opnd_i(opnd_r),
    .carry_i(stat_r[bbx_pkg::FLG_C]),
    .sel_add_i(is_addc),
    .res_o(alu_res),
    .c_o(alu_c),
    .dc_o(alu_dc),
    .ov_o(alu_ov),
    .n_o(alu_n),
    .z_o(alu_z)
  );

  // flag vectors ordered n, ov, z, dc, c
  assign flg_add = {alu_n, alu_ov, alu_z, alu_dc, alu_c};
  assign flg_and = {alu_n, stat_r[bbx_pkg::FLG_OV], alu_z,
                    stat_r[bbx_pkg::FLG_DC], stat_r[bbx_pkg::FLG_C]};

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite decode

  logic a_take;
  logic wr_now;
  logic rd_now;
  logic sw_wr;
  logic start;
  logic [31:0] rd_mux;

  assign a_take = hsel_i && htrans_i[1] && hready_i;
  assign wr_now = a_valid_r && a_write_r;
  assign rd_now = a_valid_r && !a_write_r && !hreadyout_r;
  // software writes are dropped while an instruction runs
  assign sw_wr = wr_now && !busy_r;
  assign start = sw_wr && (a_addr_r == bbx_pkg::OFS_INSTR);

  assign rd_mux =
    (a_addr_r == bbx_pkg::OFS_INSTR) ? {16'h0000, ir_r} :
    (a_addr_r == bbx_pkg::OFS_WREG) ? {24'h000000, w_r} :
    (a_addr_r == bbx_pkg::OFS_STAT) ? {27'h0000000, stat_r} :
    (a_addr_r == bbx_pkg::OFS_BANK) ? {28'h0000000, bank_r} :
    (a_addr_r == bbx_pkg::OFS_PC) ? {11'h000, pc_r} :
    (a_addr_r == bbx_pkg::OFS_CFG) ? {31'h00000000, ext_r} :
    (a_addr_r == bbx_pkg::OFS_IDXB) ? {20'h00000, idxb_r} :
    (a_addr_r == bbx_pkg::OFS_INFO) ? {28'h0000000, bad_r, cyc_r, busy_r} :
    32'h00000000;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      a_valid_r <= 1'b0;
      a_write_r <= 1'b0;
      a_addr_r <= 8'h00;
    end else if (a_take) begin
      a_valid_r <= 1'b1;
      a_write_r <= hwrite_i;
      a_addr_r <= haddr_i[7:0];
    end else if (wr_now || rd_now) begin
      a_valid_r <= 1'b0;
    end
  end

  // reads take one wait state so that hrdata comes from a flop
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      hreadyout_r <= 1'b1;
      hrdata_r <= 32'h00000000;
      hresp_r <= 1'b0;
    end else if (a_take && !hwrite_i) begin
      hreadyout_r <= 1'b0;
    end else if (rd_now) begin
      hreadyout_r <= 1'b1;
      hrdata_r <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // quarter-phase sequencer

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      bbx_pkg::ST_IDLE: state_nxt = start ? bbx_pkg::ST_Q1 : bbx_pkg::ST_IDLE;
      bbx_pkg::ST_Q1: state_nxt = bbx_pkg::ST_Q2;
      bbx_pkg::ST_Q2: state_nxt = bbx_pkg::ST_Q3;
      bbx_pkg::ST_Q3: state_nxt = bbx_pkg::ST_Q4;
      bbx_pkg::ST_Q4: state_nxt = taken_r ? bbx_pkg::ST_N1 : bbx_pkg::ST_IDLE;
      bbx_pkg::ST_N1: state_nxt = bbx_pkg::ST_N2;
      bbx_pkg::ST_N2: state_nxt = bbx_pkg::ST_N3;
      bbx_pkg::ST_N3: state_nxt = bbx_pkg::ST_N4;
      bbx_pkg::ST_N4: state_nxt = bbx_pkg::ST_IDLE;
      default: state_nxt = bbx_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_r <= bbx_pkg::ST_IDLE;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r <= (state_nxt != bbx_pkg::ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction word and software-owned configuration

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ir_r <= 16'h0000;
      bank_r <= bbx_pkg::ACC_LO_BANK;
      ext_r <= 1'b0;
      idxb_r <= 12'h000;
    end else if (sw_wr) begin
      if (a_addr_r == bbx_pkg::OFS_INSTR) ir_r <= hwdata_i[15:0];
      if (a_addr_r == bbx_pkg::OFS_BANK) bank_r <= hwdata_i[bbx_pkg::BANK_W-1:0];
      if (a_addr_r == bbx_pkg::OFS_CFG) ext_r <= hwdata_i[bbx_pkg::CFG_EXT];
      if (a_addr_r == bbx_pkg::OFS_IDXB) idxb_r <= hwdata_i[bbx_pkg::DA_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // q1: address the operand, advance the pc

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      dmem_addr_r <= 12'h000;
    end else if (state_r == bbx_pkg::ST_Q1) begin
      dmem_addr_r <= ea;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pc_r <= bbx_pkg::PC_RST;
    end else if (state_r == bbx_pkg::ST_Q1) begin
      pc_r <= pc_r + bbx_pkg::PC_STEP;
    end else if (state_r == bbx_pkg::ST_Q4 && taken_r) begin
      pc_r <= br_target;
    end else if (sw_wr && a_addr_r == bbx_pkg::OFS_PC) begin
      pc_r <= hwdata_i[bbx_pkg::PC_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // q2: read literal or file byte

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      opnd_r <= bbx_pkg::BYTE_ZERO;
    end else if (state_r == bbx_pkg::ST_Q2) begin
      opnd_r <= is_file ? dmem_rdata_i : ir_r[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // q3: process, stage result, decide the branch

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      res_r <= bbx_pkg::BYTE_ZERO;
      flg_r <= '0;
      taken_r <= 1'b0;
    end else if (state_r == bbx_pkg::ST_Q3) begin
      res_r <= alu_res;
      flg_r <= is_addc ? flg_add : flg_and;
      taken_r <= is_brc && stat_r[bbx_pkg::FLG_C];
    end
  end

  // file write strobe stands through q4 so memory captures it at q4's end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      dmem_we_r <= 1'b0;
      dmem_wdata_r <= bbx_pkg::BYTE_ZERO;
    end else if (state_r == bbx_pkg::ST_Q3) begin
      dmem_we_r <= is_file && dest_file;
      dmem_wdata_r <= alu_res;
    end else begin
      dmem_we_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // q4: write accumulator and flags

  logic q4;
  logic w_dest;
  logic flg_dest;

  assign q4 = (state_r == bbx_pkg::ST_Q4);
  assign w_dest = q4 && ((is_file && !dest_file) || is_andl);
  assign flg_dest = q4 && (is_file || is_andl);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      w_r <= bbx_pkg::BYTE_ZERO;
    end else if (w_dest) begin
      w_r <= res_r;
    end else if (sw_wr && a_addr_r == bbx_pkg::OFS_WREG) begin
      w_r <= hwdata_i[7:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      stat_r <= '0;
    end else if (flg_dest) begin
      stat_r <= flg_r;
    end else if (sw_wr && a_addr_r == bbx_pkg::OFS_STAT) begin
      stat_r <= hwdata_i[bbx_pkg::FLG_W-1:0];
    end
  end

  // cycle count of the last instruction, and unsupported-opcode marker
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cyc_r <= 2'h0;
      bad_r <= 1'b0;
    end else if (q4) begin
      cyc_r <= taken_r ? bbx_pkg::CYC_TWO : bbx_pkg::CYC_ONE;
      bad_r <= !(is_file || is_andl || is_brc);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign hrdata_o = hrdata_r;
  assign hreadyout_o = hreadyout_r;
  assign hresp_o = hresp_r;
  assign dmem_addr_o = dmem_addr_r;
  assign dmem_wdata_o = dmem_wdata_r;
  assign dmem_we_o = dmem_we_r;
  assign busy_o = busy_r;

endmodule

`default_nettype wire

// [verification/bbx_exec_monitor.sv]
// concurrent checks on the ports of the byte and branch executor
`timescale 1ns/1ps
`default_nettype none

module bbx_exec_monitor (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // bus side
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // memory side and status
  input wire logic [11:0] dmem_addr_o,
  input wire logic dmem_we_o,
  input wire logic busy_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  ////////////////////////////////////////////////////////////////
  AST_RESP_OKAY: assert property (hresp_o == 1'b0)
    else $error("bus response not okay");
  AST_READ_WAIT: assert property (hsel_i && htrans_i[1] && hready_i && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read data phase not exactly one wait cycle");
  AST_WRITE_NOWAIT: assert property (hsel_i && htrans_i[1] && hready_i && hwrite_i |=> hreadyout_o)
    else $error("write data phase stalled");
  AST_BUSY_LEN: assert property ($rose(busy_o) |-> busy_o[*4] ##1 (!busy_o or (busy_o[*4] ##1 !busy_o)))
    else $error("instruction length not four or eight cycles");
  AST_START: assert property ($rose(busy_o) |-> $past(hsel_i && htrans_i[1] && hwrite_i && haddr_i[7:0] == 8'h00, 2))
    else $error("execution started without an instruction write");
  // operand address is fixed once decode is over, so read and write hit one byte
  AST_ADDR_HELD: assert property ($rose(busy_o) |-> ##2 $stable(dmem_addr_o)[*2])
    else $error("memory address moved after decode");
  AST_WE_Q4: assert property (dmem_we_o |-> $past(busy_o, 3) ##1 !busy_o)
    else $error("memory write outside the last quarter");
  AST_WE_PULSE: assert property (dmem_we_o |=> !dmem_we_o)
    else $error("memory write strobe longer than one cycle");
endmodule

bind bbx_exec bbx_exec_monitor u_mon (
  .sys_clk_i(sys_clk_i),
  .sys_rst_i(sys_rst_i),
  .hsel_i(hsel_i),
  .haddr_i(haddr_i),
  .htrans_i(htrans_i),
  .hwrite_i(hwrite_i),
  .hready_i(hready_i),
  .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o),
  .dmem_addr_o(dmem_addr_o),
  .dmem_we_o(dmem_we_o),
  .busy_o(busy_o)
);

`default_nettype wire

// [verification/tb_byte_and_branch_exec.sv]
// self-checking bench for the byte and branch executor
`timescale 1ns/1ps
`default_nettype none

module tb_byte_and_branch_exec;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [11:0] dmem_addr;
  logic [7:0] dmem_wdata;
  logic dmem_we;
  logic [7:0] dmem_rdata;
  logic busy;
  logic [7:0] mem [0:4095];
  logic [31:0] rd;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int cyc;
  logic [15:0] bc_ins [4] = '{16'he205, 16'he205, 16'he280, 16'he27f};
  logic [31:0] bc_c [4] = '{32'h0, 32'h1, 32'h1, 32'h1};
  logic [31:0] bc_pc [4] = '{32'h102, 32'h10c, 32'h002, 32'h200};
  int bc_cyc [4] = '{4, 8, 8, 8};

  bbx_exec DUT (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .hsel_i(hsel),
    .haddr_i(haddr),
    .htrans_i(htrans),
    .hwrite_i(hwrite),
    .hsize_i(3'h2),
    .hwdata_i(hwdata),
    .hready_i(hreadyout),
    .hrdata_o(hrdata),
    .hreadyout_o(hreadyout),
    .hresp_o(hresp),
    .dmem_addr_o(dmem_addr),
    .dmem_wdata_o(dmem_wdata),
    .dmem_we_o(dmem_we),
    .dmem_rdata_i(dmem_rdata),
    .busy_o(busy)
  );

  ////////////////////////////////////////////////////////////////
  always #10 sys_clk_i = ~sys_clk_i;
  // data memory reads combinationally, writes at the edge ending the last quarter
  assign dmem_rdata = mem[dmem_addr];
  always @(posedge sys_clk_i) begin
    if (dmem_we) begin
      mem[dmem_addr] <= dmem_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // entered just after a rising edge; leaves just after the completing edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge sys_clk_i);
    while (hreadyout !== 1'b1) @(posedge sys_clk_i);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk_i);
    while (hreadyout !== 1'b1) @(posedge sys_clk_i);
    rd = hrdata;
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic run(input logic [15:0] ins, input int exp_cyc);
    xfer(8'h00, 1'b1, {16'h0, ins});
    @(posedge sys_clk_i);
    cyc = 0;
    while (busy === 1'b1) begin
      cyc++;
      @(posedge sys_clk_i);
    end
    chk("busy cycles", exp_cyc, cyc);
    xfer(8'h1c, 1'b0, 32'h0);
    // info counts whole instruction cycles of four quarters each
    chk("info cycles", exp_cyc / 4, 32'(rd[2:1]));
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
    repeat (6) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    rchk("pc reset", 8'h10, 32'h0);
    rchk("stat reset", 8'h08, 32'h0);
    xfer(8'h20, 1'b1, 32'h5a5a5a5a);
    rchk("unmapped", 8'h20, 32'h0);
    // add with carry into the accumulator
    mem[12'h010] = 8'h02;
    xfer(8'h04, 1'b1, 32'h4d);
    xfer(8'h08, 1'b1, 32'h01);
    run(16'h2010, 4);
    rchk("wreg addc", 8'h04, 32'h50);
    rchk("stat addc", 8'h08, 32'h02);
    chk("mem 010", 32'h02, {24'h0, mem[12'h010]});
    rchk("pc step", 8'h10, 32'h2);
    // add with carry back to a banked file byte, signed overflow
    mem[12'h380] = 8'h7f;
    xfer(8'h04, 1'b1, 32'h01);
    xfer(8'h08, 1'b1, 32'h00);
    xfer(8'h0c, 1'b1, 32'h3);
    run(16'h2380, 4);
    chk("mem 380", 32'h80, {24'h0, mem[12'h380]});
    rchk("wreg kept", 8'h04, 32'h01);
    rchk("stat ovf", 8'h08, 32'h1a);
    // and with file at the last indexed address, then just above it
    xfer(8'h14, 1'b1, 32'h1);
    xfer(8'h18, 1'b1, 32'h200);
    mem[12'h25f] = 8'hc2;
    mem[12'h060] = 8'hf0;
    mem[12'h260] = 8'hff;
    xfer(8'h04, 1'b1, 32'h17);
    xfer(8'h08, 1'b1, 32'h0b);
    run(16'h145f, 4);
    rchk("wreg andf", 8'h04, 32'h02);
    rchk("stat andf", 8'h08, 32'h0b);
    run(16'h1660, 4);
    chk("mem 060", 32'h00, {24'h0, mem[12'h060]});
    rchk("stat zero", 8'h08, 32'h0f);
    // and literal, negative result
    xfer(8'h04, 1'b1, 32'ha3);
    xfer(8'h08, 1'b1, 32'h09);
    run(16'h0bf0, 4);
    rchk("wreg andl", 8'h04, 32'ha0);
    rchk("stat andl", 8'h08, 32'h19);
    // branch on carry: not taken, taken, both offset extremes
    for (int i = 0; i < 4; i++) begin
      xfer(8'h10, 1'b1, 32'h100);
      xfer(8'h08, 1'b1, bc_c[i]);
      run(bc_ins[i], bc_cyc[i]);
      rchk("pc branch", 8'h10, bc_pc[i]);
    end
    // neighbouring branch opcode with carry still set: must not branch
    run(16'he305, 4);
    chk("info bad", 32'h1, 32'(rd[3]));
    rchk("pc other", 8'h10, 32'h202);
    summarize();
  end
endmodule

`default_nettype wire
